//--- src/por_pkg.sv
// shared constants for the port override and security register bank
package por_pkg;
   // ==================================================
   // register offsets (byte addresses on the plain port)
   localparam logic [7:0] POR_OFS_MGMT_FORCE = 8'h70;
   localparam logic [7:0] POR_OFS_AUTH_MODE = 8'h77;
   localparam logic [7:0] POR_OFS_AUTH_MASK = 8'h78;
   localparam logic [7:0] POR_OFS_SERDES_DEFAULT_VALUES = 8'h80;
   localparam logic [7:0] POR_OFS_EARLY_SEL = 8'h84;

   // ==================================================
   // widths
   localparam int POR_NUM_PORTS = 17;
   localparam int POR_NUM_SD_PORTS = 16;
   localparam int POR_SD_WIDTH = 17;

   // ==================================================
   // in-band management port override field positions
   localparam int POR_OVR_EN_BIT = 7;
   localparam int POR_OVR_UNTAG_BIT = 6;
   localparam int POR_OVR_TXFC_BIT = 5;
   localparam int POR_OVR_RXFC_BIT = 4;
   localparam int POR_OVR_SPD_HI = 3;
   localparam int POR_OVR_SPD_LO = 2;
   localparam int POR_OVR_DPX_BIT = 1;
   localparam int POR_OVR_LINK_BIT = 0;

   // ==================================================
   // serdes default word field positions
   localparam int POR_SD_PAUSE_HI = 16;
   localparam int POR_SD_PAUSE_LO = 15;
   localparam int POR_SD_ADV_HDX_BIT = 14;
   localparam int POR_SD_ADV_FDX_BIT = 13;
   localparam int POR_SD_TBI_BIT = 12;
   localparam int POR_SD_OPTICAL_BIT = 11;
   localparam int POR_SD_REFCLK_OFF_BIT = 10;
   localparam int POR_SD_ELAST_HI = 9;
   localparam int POR_SD_ELAST_LO = 8;
   localparam int POR_SD_FREQLOCK_BIT = 7;
   localparam int POR_SD_AUTODET_BIT = 6;
   localparam int POR_SD_PARDET_BIT = 5;
   localparam int POR_SD_EXTCRS_BIT = 4;
   localparam int POR_SD_EXTCRS_INV_BIT = 3;
   localparam int POR_SD_SIGDET_EN_BIT = 2;
   localparam int POR_SD_SIGDET_INV_BIT = 1;
   localparam int POR_SD_TXCRS_DIS_BIT = 0;

   // ==================================================
   // values after reset
   localparam logic [7:0] POR_RST_MGMT_FORCE = 8'h0B;
   localparam logic [0:0] POR_RST_AUTH_MODE = 1'h0;
   localparam logic [16:0] POR_RST_AUTH_MASK = 17'h00000;
   localparam logic [16:0] POR_RST_SERDES_DEFAULT_VALUES = 17'h06460;
   localparam logic [15:0] POR_RST_EARLY_SEL = 16'h0000;

   // ==================================================
   // forced speed encoding
   typedef enum logic [1:0]
   {
      POR_SPD_10 = 2'h0,
      POR_SPD_100 = 2'h1,
      POR_SPD_1000 = 2'h2
   } por_speed_t;
endpackage

//--- src/por_auth_filter.sv
// per-frame port security drop decision
`timescale 1ns/1ps
`default_nettype none
module por_auth_filter
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [por_pkg::POR_NUM_PORTS-1:0] mask_i,
   input wire logic mode_i,
   input wire logic frame_valid_i,
   input wire logic [4:0] frame_port_i,
   input wire logic sa_miss_i,
   input wire logic auth_frame_i,
   output logic drop_valid_o,
   output logic drop_o
);
   import por_pkg::*;

   logic port_secured;
   logic drop_d;

   // ==================================================
   // decision
   // ports beyond the mask width are never filtered
   assign port_secured = (frame_port_i < 5'(POR_NUM_PORTS)) && mask_i[frame_port_i];
   // strict mode drops all but authentication frames on secured ports
   assign drop_d = port_secured && !auth_frame_i && (mode_i || sa_miss_i);

   // registered verdict, one cycle after the frame is offered
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         drop_valid_o <= 1'b0;
         drop_o <= 1'b0;
      end
      else
      begin
         drop_valid_o <= frame_valid_i;
         drop_o <= frame_valid_i && drop_d;
      end
   end

   // ==================================================
   // checks
   a_drop_strict: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      frame_valid_i && port_secured && mode_i && !auth_frame_i |=> drop_o)
      else $error("strict mode failed to drop");
   a_drop_unsecured: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      frame_valid_i && !port_secured |=> drop_valid_o && !drop_o)
      else $error("frame dropped on unsecured port");
   a_drop_auth_pass: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      frame_valid_i && auth_frame_i |=> !drop_o)
      else $error("authentication frame dropped");
   c_drop_miss: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      frame_valid_i && port_secured && !mode_i && sa_miss_i ##1 drop_o);
endmodule
`default_nettype wire

//--- src/por_regs.sv
// port override, port security and serdes default register bank
`timescale 1ns/1ps
`default_nettype none
module por_regs
(
   input wire logic CLK_I,
   input wire logic RST_N_I,
   // register port
   input wire logic [7:0] ADDR_I,
   input wire logic [31:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [31:0] RDATA_O,
   // phy scan status of the management port
   input wire logic MGMT_MODE_I,
   input wire logic SCAN_LINK_I,
   input wire logic SCAN_DUPLEX_I,
   input wire logic [1:0] SCAN_SPEED_I,
   input wire logic SCAN_TXFC_I,
   input wire logic SCAN_RXFC_I,
   // effective management port state
   output logic LINK_O,
   output logic DUPLEX_O,
   output logic SPEED_10_O,
   output logic SPEED_100_O,
   output logic SPEED_1000_O,
   output logic TXFC_O,
   output logic RXFC_O,
   output logic UNTAGGED_PAUSE_DETECT_SEL_O,
   // security filter frame interface
   input wire logic FRAME_VALID_I,
   input wire logic [4:0] FRAME_PORT_I,
   input wire logic SA_MISS_I,
   input wire logic AUTH_FRAME_I,
   output logic DROP_VALID_O,
   output logic DROP_O,
   // serdes defaults
   output logic [por_pkg::POR_SD_WIDTH-1:0] SERDES_DEFAULT_WORD_O,
   output logic [1:0] SD_PAUSE_ADV_O,
   output logic [1:0] SD_ELASTICITY_O,
   output logic REFCLK_OUT_OFF_DEFAULT_O,
   output logic SIGNAL_DETECT_ON_DEFAULT_O,
   output logic SIGNAL_DETECT_INVERT_DEFAULT_O,
   // carrier sense and collision selection
   input wire logic [por_pkg::POR_NUM_SD_PORTS-1:0] REG_CRS_I,
   input wire logic [por_pkg::POR_NUM_SD_PORTS-1:0] EARLY_CRS_I,
   input wire logic [por_pkg::POR_NUM_SD_PORTS-1:0] REG_COL_I,
   input wire logic [por_pkg::POR_NUM_SD_PORTS-1:0] EARLY_COL_I,
   output logic [por_pkg::POR_NUM_SD_PORTS-1:0] EARLY_CARRIER_SELECT_O,
   output logic [por_pkg::POR_NUM_SD_PORTS-1:0] CRS_O,
   output logic [por_pkg::POR_NUM_SD_PORTS-1:0] COL_O
);
   import por_pkg::*;

   logic [7:0] force_q;
   logic [0:0] mode_q;
   logic [POR_NUM_PORTS-1:0] mask_q;
   logic [POR_SD_WIDTH-1:0] sd_q;
   logic [POR_NUM_SD_PORTS-1:0] early_q;
   logic [31:0] rdata_d;
   logic [1:0] speed_d;

   // one-hot decode of a speed code; unused code 3 gives no speed
   function automatic logic [2:0] spd_onehot(input logic [1:0] code);
      logic [2:0] oh;
      oh = 3'h0;
      case (code)
         POR_SPD_10: oh = 3'h1;
         POR_SPD_100: oh = 3'h2;
         POR_SPD_1000: oh = 3'h4;
         default: oh = 3'h0;
      endcase
      return oh;
   endfunction

   // ==================================================
   // register writes
   // management port override; software has to force link since no negotiation runs
   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
         force_q <= POR_RST_MGMT_FORCE;
      else if (WR_I && ADDR_I == POR_OFS_MGMT_FORCE)
         force_q <= WDATA_I[7:0];
   end

   // security filter mode, only bit 0 is storage
   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
         mode_q <= POR_RST_AUTH_MODE;
      else if (WR_I && ADDR_I == POR_OFS_AUTH_MODE)
         mode_q <= WDATA_I[0:0];
   end

   // per-port security enable mask
   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
         mask_q <= POR_RST_AUTH_MASK;
      else if (WR_I && ADDR_I == POR_OFS_AUTH_MASK)
         mask_q <= WDATA_I[POR_NUM_PORTS-1:0];
   end

   // serdes default word
   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
         sd_q <= POR_RST_SERDES_DEFAULT_VALUES;
      else if (WR_I && ADDR_I == POR_OFS_SERDES_DEFAULT_VALUES)
         sd_q <= WDATA_I[POR_SD_WIDTH-1:0];
   end

   // early carrier select, one bit per serdes port
   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
         early_q <= POR_RST_EARLY_SEL;
      else if (WR_I && ADDR_I == POR_OFS_EARLY_SEL)
         early_q <= WDATA_I[POR_NUM_SD_PORTS-1:0];
   end

   // ==================================================
   // register reads
   // unmapped addresses and reserved bits read zero
   always_comb
   begin
      rdata_d = 32'h0;
      case (ADDR_I)
         POR_OFS_MGMT_FORCE: rdata_d[7:0] = force_q;
         POR_OFS_AUTH_MODE: rdata_d[0:0] = mode_q;
         POR_OFS_AUTH_MASK: rdata_d[POR_NUM_PORTS-1:0] = mask_q;
         POR_OFS_SERDES_DEFAULT_VALUES: rdata_d[POR_SD_WIDTH-1:0] = sd_q;
         POR_OFS_EARLY_SEL: rdata_d[POR_NUM_SD_PORTS-1:0] = early_q;
         default: rdata_d = 32'h0;
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
         RDATA_O <= 32'h0;
      else if (RD_I)
         RDATA_O <= rdata_d;
      else
         RDATA_O <= 32'h0;
   end

   // ==================================================
   // management port state
   // override replaces scanned status only while the enable bit is set
   assign speed_d = force_q[POR_OVR_EN_BIT] ? force_q[POR_OVR_SPD_HI:POR_OVR_SPD_LO]
                                            : SCAN_SPEED_I;

   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
      begin
         LINK_O <= 1'b0;
         DUPLEX_O <= 1'b0;
         TXFC_O <= 1'b0;
         RXFC_O <= 1'b0;
      end
      else if (force_q[POR_OVR_EN_BIT])
      begin
         LINK_O <= force_q[POR_OVR_LINK_BIT];
         DUPLEX_O <= force_q[POR_OVR_DPX_BIT];
         TXFC_O <= force_q[POR_OVR_TXFC_BIT];
         RXFC_O <= force_q[POR_OVR_RXFC_BIT];
      end
      else
      begin
         LINK_O <= SCAN_LINK_I;
         DUPLEX_O <= SCAN_DUPLEX_I;
         TXFC_O <= SCAN_TXFC_I;
         RXFC_O <= SCAN_RXFC_I;
      end
   end

   // speed decode, kept one-hot for codes 0 to 2 so the mac sees a single rate
   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
         {SPEED_1000_O, SPEED_100_O, SPEED_10_O} <= 3'h0;
      else
         {SPEED_1000_O, SPEED_100_O, SPEED_10_O} <= spd_onehot(speed_d);
   end

   // outside management use no vendor tag exists, so standard pause detection applies
   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
         UNTAGGED_PAUSE_DETECT_SEL_O <= 1'b1;
      else
         UNTAGGED_PAUSE_DETECT_SEL_O <= !MGMT_MODE_I || force_q[POR_OVR_UNTAG_BIT];
   end

   // ==================================================
   // serdes default fields
   assign SERDES_DEFAULT_WORD_O = sd_q;
   assign SD_PAUSE_ADV_O = sd_q[POR_SD_PAUSE_HI:POR_SD_PAUSE_LO];
   assign SD_ELASTICITY_O = sd_q[POR_SD_ELAST_HI:POR_SD_ELAST_LO];
   assign REFCLK_OUT_OFF_DEFAULT_O = sd_q[POR_SD_REFCLK_OFF_BIT];
   assign SIGNAL_DETECT_ON_DEFAULT_O = sd_q[POR_SD_SIGDET_EN_BIT];
   assign SIGNAL_DETECT_INVERT_DEFAULT_O = sd_q[POR_SD_SIGDET_INV_BIT];
   assign EARLY_CARRIER_SELECT_O = early_q;

   // ==================================================
   // per-port carrier and collision selection
   // registered so a select change never glitches the mac inputs
   for (genvar p = 0; p < POR_NUM_SD_PORTS; p++)
   begin : g_crs
      always_ff @(posedge CLK_I)
      begin
         if (!RST_N_I)
         begin
            CRS_O[p] <= 1'b0;
            COL_O[p] <= 1'b0;
         end
         else
         begin
            CRS_O[p] <= early_q[p] ? EARLY_CRS_I[p] : REG_CRS_I[p];
            COL_O[p] <= early_q[p] ? EARLY_COL_I[p] : REG_COL_I[p];
         end
      end
   end

   // ==================================================
   // security filter
   por_auth_filter u_filter
   (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .mask_i(mask_q),
      .mode_i(mode_q[0]),
      .frame_valid_i(FRAME_VALID_I),
      .frame_port_i(FRAME_PORT_I),
      .sa_miss_i(SA_MISS_I),
      .auth_frame_i(AUTH_FRAME_I),
      .drop_valid_o(DROP_VALID_O),
      .drop_o(DROP_O)
   );

   // ==================================================
   // checks
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!RST_N_I);

   // the sampled reset term keeps the release edge out, where outputs still hold reset values
   a_force_link: assert property (RST_N_I && force_q[POR_OVR_EN_BIT] |=>
      LINK_O == $past(force_q[POR_OVR_LINK_BIT]) && DUPLEX_O == $past(force_q[POR_OVR_DPX_BIT]))
      else $error("forced link or duplex not applied");
   a_scan_pass: assert property (RST_N_I && !force_q[POR_OVR_EN_BIT] |=>
      LINK_O == $past(SCAN_LINK_I) && TXFC_O == $past(SCAN_TXFC_I))
      else $error("scanned status not passed through");
   a_speed_decode: assert property (RST_N_I && speed_d == POR_SPD_1000 ##1 1'b1 |->
      SPEED_1000_O && !SPEED_100_O && !SPEED_10_O)
      else $error("gigabit speed decode wrong");
   a_pause_select: assert property (RST_N_I && MGMT_MODE_I |=>
      UNTAGGED_PAUSE_DETECT_SEL_O == $past(force_q[POR_OVR_UNTAG_BIT]))
      else $error("pause detect select wrong in management use");
   a_reset_values: assert property (!$past(RST_N_I) |->
      force_q == POR_RST_MGMT_FORCE && sd_q == POR_RST_SERDES_DEFAULT_VALUES && mask_q == 17'h00000)
      else $error("register value after reset wrong");
   a_force_readback: assert property (WR_I && ADDR_I == POR_OFS_MGMT_FORCE
      ##1 RD_I && ADDR_I == POR_OFS_MGMT_FORCE |=> RDATA_O == {24'h0, $past(WDATA_I[7:0], 2)})
      else $error("override register read back wrong");
   a_reserved_zero: assert property (RD_I && ADDR_I == POR_OFS_AUTH_MODE |=>
      RDATA_O[31:1] == 31'h0)
      else $error("reserved bits not zero");
   a_sd_write: assert property (WR_I && ADDR_I == POR_OFS_SERDES_DEFAULT_VALUES |=>
      SERDES_DEFAULT_WORD_O == $past(WDATA_I[16:0]))
      else $error("serdes default word not updated");
   a_early_mux: assert property (RST_N_I ##1 1'b1 |->
      CRS_O == (($past(early_q) & $past(EARLY_CRS_I)) | (~$past(early_q) & $past(REG_CRS_I))))
      else $error("carrier select mux wrong");
   a_rdata_idle: assert property (!RD_I |=> RDATA_O == 32'h0)
      else $error("read data outside read cycle");

   c_force_8b: cover property (WR_I && ADDR_I == POR_OFS_MGMT_FORCE && WDATA_I[7:0] == 8'h8B);
   c_strict_drop: cover property (mode_q[0] && DROP_O);
   c_early_on: cover property (|early_q ##1 |CRS_O);
   c_scan_speed: cover property (!force_q[POR_OVR_EN_BIT] ##1 SPEED_100_O);
endmodule
`default_nettype wire

//--- tb/por_regs_bench.sv
// self-checking bench for the port override and security register bank
`timescale 1ns/1ps
`default_nettype none
module por_regs_bench;
   import por_pkg::*;
   // ==================================================
   // stimulus and observed signals
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic wstb = 1'h0;
   logic rstb = 1'h0;
   logic mgmt = 1'h1;
   logic s_link = 1'h1;
   logic s_dpx = 1'h0;
   logic s_tx = 1'h1;
   logic s_rx = 1'h0;
   logic fv = 1'h0;
   logic miss = 1'h0;
   logic auth = 1'h0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [1:0] s_spd = 2'h1;
   logic [4:0] port = 5'h00;
   logic [15:0] rcrs = 16'h0F0F;
   logic [15:0] ecrs = 16'h3C3C;
   logic [15:0] rcol = 16'h1234;
   logic [15:0] ecol = 16'hFEDC;
   logic [31:0] rdata;
   logic link, dpx, s10, s100, s1000, txfc, rxfc, untag, dv, drop, refoff, sdon, sdinv;
   logic [16:0] sdw;
   logic [1:0] pause, elast;
   logic [15:0] esel, crs, col;
   int mismatches = 0;
   int checks = 0;

   por_regs u_dut
   (
      .CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wstb),
      .RD_I(rstb), .RDATA_O(rdata), .MGMT_MODE_I(mgmt), .SCAN_LINK_I(s_link),
      .SCAN_DUPLEX_I(s_dpx), .SCAN_SPEED_I(s_spd), .SCAN_TXFC_I(s_tx), .SCAN_RXFC_I(s_rx),
      .LINK_O(link), .DUPLEX_O(dpx), .SPEED_10_O(s10), .SPEED_100_O(s100),
      .SPEED_1000_O(s1000), .TXFC_O(txfc), .RXFC_O(rxfc), .UNTAGGED_PAUSE_DETECT_SEL_O(untag),
      .FRAME_VALID_I(fv), .FRAME_PORT_I(port), .SA_MISS_I(miss), .AUTH_FRAME_I(auth),
      .DROP_VALID_O(dv), .DROP_O(drop), .SERDES_DEFAULT_WORD_O(sdw), .SD_PAUSE_ADV_O(pause),
      .SD_ELASTICITY_O(elast), .REFCLK_OUT_OFF_DEFAULT_O(refoff),
      .SIGNAL_DETECT_ON_DEFAULT_O(sdon), .SIGNAL_DETECT_INVERT_DEFAULT_O(sdinv),
      .REG_CRS_I(rcrs), .EARLY_CRS_I(ecrs), .REG_COL_I(rcol), .EARLY_COL_I(ecol),
      .EARLY_CARRIER_SELECT_O(esel), .CRS_O(crs), .COL_O(col)
   );

   // 10 MHz core clock
   always #50 clk = ~clk;

   // ==================================================
   // shared helpers; every task but the first do_reset at time 0 is entered just after a rising edge
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wstb <= 1'h1;
      @(posedge clk);
      wstb <= 1'h0;
   endtask

   // read data stand only in the cycle after the strobe, so look there
   task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp);
      addr <= a;
      rstb <= 1'h1;
      @(posedge clk);
      rstb <= 1'h0;
      #1;
      chk("read data", rdata, exp);
      @(posedge clk);
   endtask

   task automatic do_reset;
      rst_n <= 1'h0;
      repeat (10) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
   endtask

   // effective port state: forced fields win only while bit 7 is set, except bit 6, which sets the untagged select in management use regardless
   function automatic logic [7:0] exp_state(input logic [7:0] v);
      logic [1:0] sp;
      logic [3:0] f;
      sp = v[7] ? v[3:2] : s_spd;
      f = v[7] ? {v[0], v[1], v[5], v[4]} : {s_link, s_dpx, s_tx, s_rx};
      return {f[3], f[2], sp == 2'h0, sp == 2'h1, sp == 2'h2, f[1], f[0], ~mgmt | v[6]};
   endfunction

   // ==================================================
   // scenarios
   task automatic t_reset;
      bus_wr(POR_OFS_MGMT_FORCE, 32'h0000_00F0);
      do_reset();
      bus_rd(POR_OFS_MGMT_FORCE, 32'h0000_000B);
      bus_rd(POR_OFS_AUTH_MODE, 32'h0);
      bus_rd(POR_OFS_AUTH_MASK, 32'h0);
      bus_rd(POR_OFS_SERDES_DEFAULT_VALUES, 32'h0000_6460);
      bus_rd(POR_OFS_EARLY_SEL, 32'h0);
      #1;
      chk("serdes word", 32'(sdw), 32'h0000_6460);
      chk("serdes fields", 32'({pause, elast, refoff, sdon, sdinv}), 32'h04);
      chk("reset state", 32'({link, dpx, s10, s100, s1000, txfc, rxfc, untag}), 32'(exp_state(8'h0B)));
      @(posedge clk);
      $display("test reset done");
   endtask

   // last entry is the usual forced-up setting for a processor link
   task automatic t_override;
      logic [7:0] tbl [7] = '{8'h4B, 8'hCB, 8'h81, 8'hA6, 8'h9A, 8'h8C, 8'h8B};
      foreach (tbl[i])
      begin
         bus_wr(POR_OFS_MGMT_FORCE, {24'h0, tbl[i]});
         @(posedge clk);
         #1;
         chk("port state", 32'({link, dpx, s10, s100, s1000, txfc, rxfc, untag}), 32'(exp_state(tbl[i])));
         @(posedge clk);
         bus_rd(POR_OFS_MGMT_FORCE, {24'h0, tbl[i]});
      end
      mgmt <= 1'h0;
      @(posedge clk);
      #1;
      chk("untagged select", 32'(untag), 32'h1);
      @(posedge clk);
      // a read right behind a write must see the new value
      bus_wr(POR_OFS_MGMT_FORCE, 32'hFFFF_FF4A);
      bus_rd(POR_OFS_MGMT_FORCE, 32'h0000_004A);
      bus_wr(POR_OFS_MGMT_FORCE, 32'h0000_008B);
      @(posedge clk);
      $display("test override done");
   endtask

   // ports 0, 3 and 16 guarded; 17 lies past the mask
   task automatic t_filter;
      logic [4:0] ports [5] = '{5'h00, 5'h03, 5'h04, 5'h10, 5'h11};
      logic [16:0] m;
      m = 17'h10009;
      bus_wr(POR_OFS_AUTH_MASK, {15'h7FFF, m});
      bus_rd(POR_OFS_AUTH_MASK, {15'h0, m});
      for (int md = 0; md < 2; md++)
      begin
         bus_wr(POR_OFS_AUTH_MODE, {31'h7FFF_FFFF, md[0]});
         bus_rd(POR_OFS_AUTH_MODE, {31'h0, md[0]});
         foreach (ports[i])
         begin
            for (int k = 0; k < 4; k++)
            begin
               port <= ports[i];
               miss <= k[0];
               auth <= k[1];
               fv <= 1'h1;
               @(posedge clk);
               fv <= 1'h0;
               #1;
               chk("drop", 32'({dv, drop}), 32'({1'h1, ports[i] < 5'h11 && m[ports[i]] && !k[1] && (md[0] || k[0])}));
               @(posedge clk);
            end
         end
      end
      $display("test filter done");
   endtask

   task automatic t_serdes;
      logic [31:0] v [2] = '{32'hFFFF_8D06, 32'h0000_72F9};
      logic [16:0] e;
      foreach (v[i])
      begin
         e = v[i][16:0];
         bus_wr(POR_OFS_SERDES_DEFAULT_VALUES, v[i]);
         bus_rd(POR_OFS_SERDES_DEFAULT_VALUES, {15'h0, e});
         #1;
         chk("serdes word", 32'(sdw), 32'(e));
         chk("serdes fields", 32'({pause, elast, refoff, sdon, sdinv}), 32'({e[16:15], e[9:8], e[10], e[2], e[1]}));
         @(posedge clk);
      end
      $display("test serdes done");
   endtask

   task automatic t_early;
      logic [15:0] s;
      s = 16'hA5C3;
      bus_wr(POR_OFS_EARLY_SEL, {16'hFFFF, s});
      bus_rd(POR_OFS_EARLY_SEL, {16'h0, s});
      #1;
      chk("early select", 32'(esel), 32'(s));
      chk("carrier", 32'(crs), 32'((s & ecrs) | (~s & rcrs)));
      chk("collision", 32'(col), 32'((s & ecol) | (~s & rcol)));
      @(posedge clk);
      $display("test early done");
   endtask

   // holes between registers must neither store nor disturb neighbours
   task automatic t_unmapped;
      bus_wr(8'h71, 32'hFFFF_FFFF);
      @(posedge clk);
      bus_wr(8'h85, 32'hFFFF_FFFF);
      bus_rd(8'h71, 32'h0);
      bus_rd(8'h00, 32'h0);
      bus_rd(POR_OFS_MGMT_FORCE, 32'h0000_008B);
      bus_rd(POR_OFS_EARLY_SEL, 32'h0000_A5C3);
      $display("test unmapped done");
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ==================================================
   // main sequence
   initial
   begin
      do_reset();
      t_reset();
      t_override();
      t_filter();
      t_serdes();
      t_early();
      t_unmapped();
      tally_and_finish();
   end

   // watchdog; the whole run needs well under a thousand cycles
   initial
   begin
      repeat (5000) @(posedge clk);
      mismatches++;
      $display("mismatch watchdog expected finish seen hang");
      tally_and_finish();
   end
endmodule
`default_nettype wire
